// ### lpc_pkg.sv
`default_nettype none

package lpc_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] PHY_CTRL_OFFSET = 8'h18;
    localparam logic [7:0] PHY_CTRL_RESET = 8'h00;
    localparam int BIT_OT_IRQ_ENABLE = 7;
    localparam int BIT_OT_PRESENT = 6;
    localparam int BIT_RX_STATUS = 5;
    localparam int BIT_DIRECT_TX = 4;
    localparam int BIT_UV_SHUTDOWN_DISABLE = 3;
    localparam int BIT_PHY_ENABLE = 2;
    localparam int SLEW_LSB = 0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 50;
    localparam int WAKE_FILTER_TIME_NS = 100000;
    // Least time, so round up to whole cycles
    localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] WAKE_CNT_LIMIT = 12'(WAKE_FILTER_CYCLES);
    localparam logic [11:0] WAKE_CNT_RESET = 12'h000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        SLEW_NORMAL = 2'b00,
        SLEW_SLOW = 2'b01,
        SLEW_FAST = 2'b10,
        SLEW_NORMAL_ALT = 2'b11
    } lpc_slew_e;

    typedef enum logic [0:0] {
        LV_DRIVE = 1'b0,
        LV_HOLD = 1'b1
    } lpc_lv_state_e;

    typedef struct packed {
        logic overtemp_irq_enable;
        logic direct_tx;
        logic undervolt_shutdown_disable;
        logic phy_enable;
        logic [1:0] slew_select;
    } lpc_ctrl_s;

    localparam lpc_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0};

    typedef struct packed {
        logic overtemp;
        logic supply_undervoltage;
        logic bus_rx;
    } lpc_ana_s;

endpackage

`default_nettype wire

// ### lpc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for asynchronous levels
// ==========================================================
module lpc_sync
    import lpc_pkg::*;
#(
    parameter lpc_ana_s RESET_VAL = '{1'b0, 1'b0, 1'b1}
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire lpc_ana_s async_in,
    output var lpc_ana_s sync_out
);

    lpc_ana_s meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            meta_r <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // lpc_sync

`default_nettype wire

// ### lpc_top.sv
// Summary of operation
// - Slew code 00 and 11 give normal, 01 slow, 10 fast slope.
// - After reset the normal slew setting is selected.
// - Overtemperature disables transmitter; status bit 6 set while condition lasts.
// - Overtemperature event with enable bit 7 set raises an interrupt request.
// - Reading the control register clears the pending overtemperature interrupt.
// - New interrupt only after condition vanished and reappeared.
// - Transmitter re-enabled once overtemperature cleared and transmit data high.
// - Low-power mode keeps transmitter off, receiver still watches the bus.
// - Long dominant then rising edge makes a wake event, recorded.
// - Undervoltage with shutdown active releases bus at next recessive point.
// - After undervoltage ends, drive resumes once transmit is recessive.
// - Shutdown disable bit set keeps driver functional during undervoltage.
// - Receiver status bit 5 reads 0 dominant, 1 recessive.
// - Direct transmit bit forces dominant; inverted transmit data ORed in.
// - Enable bit 2 switches the physical layer off or on.
// - Control register resets to all zeros.
`timescale 1ns/1ps
`default_nettype none

module lpc_top
    import lpc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic txd_in,
    input wire logic low_power_in,
    input wire logic overtemp_in,
    input wire logic supply_undervoltage_in,
    input wire logic lin_rx_in,
    input wire logic wake_clear_in,
    output logic lin_drive_dominant_out,
    output logic phy_active_out,
    output logic [1:0] slew_code_out,
    output logic rxd_out,
    output logic overtemp_irq_out,
    output logic wake_source_out
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic addr_hit(input logic [7:0] addr);
        addr_hit = (addr == PHY_CTRL_OFFSET);
    endfunction

    function automatic lpc_slew_e slew_map(input logic [1:0] code);
        case (code)
            SLEW_SLOW: slew_map = SLEW_SLOW;
            SLEW_FAST: slew_map = SLEW_FAST;
            default: slew_map = SLEW_NORMAL;
        endcase
    endfunction

    lpc_ctrl_s ctrl_r;
    lpc_ana_s ana_raw;
    lpc_ana_s ana_sync;
    logic wr_hit;
    logic rd_hit;
    logic ot_prev_r;
    logic ot_rise;
    logic ot_pending_r;
    logic ot_shut_r;
    logic dom_req;
    logic drive_nxt;
    lpc_lv_state_e lv_state_r;
    logic [11:0] dom_cnt_r;
    logic rx_prev_r;
    logic wake_event;

    assign wr_hit = reg_wr_in && addr_hit(reg_addr_in);
    assign rd_hit = reg_rd_in && addr_hit(reg_addr_in);
    assign ana_raw = '{overtemp_in, supply_undervoltage_in, lin_rx_in};

    // ==========================================================
    // Input synchronisation
    // ==========================================================
    // Analog flags change with no regard to the bus clock
    lpc_sync u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(ana_raw),
        .sync_out(ana_sync)
    );

    // ==========================================================
    // Control register
    // ==========================================================
    // Only writable fields are stored; bits 6 and 5 are live status
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_r <= CTRL_RESET;
            slew_code_out <= SLEW_NORMAL;
        end
        else if (wr_hit)
        begin
            ctrl_r.overtemp_irq_enable <= reg_wdata_in[BIT_OT_IRQ_ENABLE];
            ctrl_r.direct_tx <= reg_wdata_in[BIT_DIRECT_TX];
            ctrl_r.undervolt_shutdown_disable <= reg_wdata_in[BIT_UV_SHUTDOWN_DISABLE];
            ctrl_r.phy_enable <= reg_wdata_in[BIT_PHY_ENABLE];
            ctrl_r.slew_select <= reg_wdata_in[SLEW_LSB +: 2];
            slew_code_out <= slew_map(reg_wdata_in[SLEW_LSB +: 2]);
        end
    end

    // Read data; unmapped reads return zero
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            reg_rdata_out <= PHY_CTRL_RESET;
        else if (reg_rd_in)
        begin
            if (rd_hit)
                reg_rdata_out <= {ctrl_r.overtemp_irq_enable, ana_sync.overtemp,
                                  ana_sync.bus_rx, ctrl_r.direct_tx,
                                  ctrl_r.undervolt_shutdown_disable, ctrl_r.phy_enable,
                                  ctrl_r.slew_select};
            else
                reg_rdata_out <= 8'h00;
        end
    end

    // ==========================================================
    // Overtemperature interrupt and shutdown
    // ==========================================================
    assign ot_rise = ana_sync.overtemp && !ot_prev_r;

    // Set beats a simultaneous read so a fresh event is never lost
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            ot_prev_r <= 1'b0;
            ot_pending_r <= 1'b0;
            overtemp_irq_out <= 1'b0;
        end
        else
        begin
            ot_prev_r <= ana_sync.overtemp;
            if (ot_rise)
                ot_pending_r <= 1'b1;
            else if (rd_hit)
                ot_pending_r <= 1'b0;
            overtemp_irq_out <= ot_pending_r && ctrl_r.overtemp_irq_enable;
        end
    end

    // Shutdown latch waits for a recessive transmit input to avoid a glitch
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            ot_shut_r <= 1'b0;
        else if (ana_sync.overtemp)
            ot_shut_r <= 1'b1;
        else if (txd_in)
            ot_shut_r <= 1'b0;
    end

    // ==========================================================
    // Low-voltage shutdown
    // ==========================================================
    assign dom_req = !txd_in || ctrl_r.direct_tx;

    // Undervoltage only ever releases the bus at a recessive point, never cuts it mid-bit
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            lv_state_r <= LV_DRIVE;
        else
        begin
            case (lv_state_r)
                LV_DRIVE:
                    if (ana_sync.supply_undervoltage && !ctrl_r.undervolt_shutdown_disable
                        && !dom_req)
                        lv_state_r <= LV_HOLD;
                LV_HOLD:
                    if (ctrl_r.undervolt_shutdown_disable)
                        lv_state_r <= LV_DRIVE;
                    else if (!ana_sync.supply_undervoltage && !dom_req)
                        lv_state_r <= LV_DRIVE;
                default:
                    lv_state_r <= LV_DRIVE;
            endcase
        end
    end

    // ==========================================================
    // Transmit path
    // ==========================================================
    assign drive_nxt = ctrl_r.phy_enable && !low_power_in
                       && !ana_sync.overtemp && !ot_shut_r
                       && (lv_state_r == LV_DRIVE) && dom_req;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            lin_drive_dominant_out <= 1'b0;
            phy_active_out <= 1'b0;
            rxd_out <= 1'b1;
        end
        else
        begin
            lin_drive_dominant_out <= drive_nxt;
            phy_active_out <= ctrl_r.phy_enable;
            // Receiver stays live in low power to catch wake-ups
            rxd_out <= (ctrl_r.phy_enable || low_power_in) ? ana_sync.bus_rx : 1'b1;
        end
    end

    // ==========================================================
    // Wake-up detection
    // ==========================================================
    assign wake_event = low_power_in && ana_sync.bus_rx && !rx_prev_r
                        && (dom_cnt_r >= WAKE_CNT_LIMIT);

    // Counter saturates so an endless dominant cannot wrap into a miss
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            dom_cnt_r <= WAKE_CNT_RESET;
            rx_prev_r <= 1'b1;
        end
        else
        begin
            rx_prev_r <= ana_sync.bus_rx;
            if (!low_power_in || ana_sync.bus_rx)
                dom_cnt_r <= WAKE_CNT_RESET;
            else if (dom_cnt_r < WAKE_CNT_LIMIT)
                dom_cnt_r <= dom_cnt_r + 12'h001;
        end
    end

    // Wake source flag; set wins over clear
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            wake_source_out <= 1'b0;
        else if (wake_event)
            wake_source_out <= 1'b1;
        else if (wake_clear_in)
            wake_source_out <= 1'b0;
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_slew_map;
        wr_hit |=> (slew_code_out == ($past(reg_wdata_in[1:0]) == 2'b11 ? 2'b00
                                       : $past(reg_wdata_in[1:0])));
    endproperty
    a_slew_map: assert property (p_slew_map) else $error("slew code mismatch");
    property p_reset_state;
        @(posedge clk_in) disable iff (1'b0)
        !reset_n_in |=> (ctrl_r == CTRL_RESET) && (slew_code_out == SLEW_NORMAL);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    property p_ot_off;
        ana_sync.overtemp |=> !lin_drive_dominant_out;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("drive during overtemp");
    property p_status_read;
        rd_hit |=> reg_rdata_out[6] == $past(ana_sync.overtemp)
                   && reg_rdata_out[5] == $past(ana_sync.bus_rx);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits wrong");
    sequence s_ot_event;
        ot_rise && ctrl_r.overtemp_irq_enable && !wr_hit;
    endsequence
    sequence s_irq_up;
        ##1 ot_pending_r ##1 overtemp_irq_out;
    endsequence
    property p_irq;
        s_ot_event |-> s_irq_up;
    endproperty
    a_irq: assert property (p_irq) else $error("no overtemp irq");
    property p_ack;
        rd_hit && !ot_rise |=> !ot_pending_r;
    endproperty
    a_ack: assert property (p_ack) else $error("read did not ack");
    property p_no_retrigger;
        ana_sync.overtemp && ot_prev_r && !ot_pending_r |=> !ot_pending_r;
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("irq retriggered");
    property p_reenable;
        ot_shut_r && !ana_sync.overtemp && txd_in |=> !ot_shut_r;
    endproperty
    a_reenable: assert property (p_reenable) else $error("no re-enable");
    property p_low_power;
        low_power_in |=> !lin_drive_dominant_out;
    endproperty
    a_low_power: assert property (p_low_power) else $error("drive in low power");
    property p_wake;
        low_power_in && ana_sync.bus_rx && !rx_prev_r && dom_cnt_r == WAKE_CNT_LIMIT
            |=> wake_source_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");
    property p_lv_hold;
        lv_state_r == LV_HOLD |=> !lin_drive_dominant_out;
    endproperty
    a_lv_hold: assert property (p_lv_hold) else $error("drive during lv hold");
    // Direct transmit counts as a dominant request, so release waits on it too
    property p_lv_resume;
        !ana_sync.supply_undervoltage && !dom_req |=> lv_state_r == LV_DRIVE;
    endproperty
    a_lv_resume: assert property (p_lv_resume) else $error("lv not released");
    property p_uv_disable;
        ctrl_r.undervolt_shutdown_disable |=> lv_state_r == LV_DRIVE;
    endproperty
    a_uv_disable: assert property (p_uv_disable) else $error("lv hold despite disable");
    property p_direct_tx;
        ctrl_r.direct_tx && ctrl_r.phy_enable && !low_power_in && !ana_sync.overtemp
            && !ot_shut_r && lv_state_r == LV_DRIVE |=> lin_drive_dominant_out;
    endproperty
    a_direct_tx: assert property (p_direct_tx) else $error("direct tx not dominant");

    property p_disabled;
        !ctrl_r.phy_enable |=> !lin_drive_dominant_out && !phy_active_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("drive while disabled");

endmodule // lpc_top

`default_nettype wire

// ### lpc_lin_node.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Other node on the single-wire bus
// ==========================================================
module lpc_lin_node
(
    input wire logic clk_in,
    input wire logic dut_dominant_in,
    output logic bus_level_out
);
    logic node_dom_r;

    initial node_dom_r = 1'b0;

    // Wired-AND with pull-up: recessive unless some node pulls the line low
    assign bus_level_out = ~(dut_dominant_in | node_dom_r);

    // Hold the bus dominant for n cycles, changing only after falling edges
    task automatic send_dominant(input int n);
        @(negedge clk_in);
        node_dom_r = 1'b1;
        repeat (n) @(negedge clk_in);
        node_dom_r = 1'b0;
    endtask
endmodule // lpc_lin_node

`default_nettype wire

// ### lpc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module lpc_top_bench;
    import lpc_pkg::*;
    logic clk_in, reset_n_in, reg_wr, reg_rd, txd, low_power, overtemp, uv, wake_clear;
    logic [7:0] reg_addr, reg_wdata, rdata, v;
    logic drive, active, rxd, irq, wake, bus_level;
    logic [1:0] slew;
    int n_fail, checks;

    // ==========================================================
    // Design and far side
    // ==========================================================
    lpc_top u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .txd_in(txd), .low_power_in(low_power),
        .overtemp_in(overtemp), .supply_undervoltage_in(uv), .lin_rx_in(bus_level),
        .wake_clear_in(wake_clear), .lin_drive_dominant_out(drive),
        .phy_active_out(active), .slew_code_out(slew), .rxd_out(rxd),
        .overtemp_irq_out(irq), .wake_source_out(wake));

    lpc_lin_node u_node (.clk_in(clk_in), .dut_dominant_in(drive), .bus_level_out(bus_level));

    // Clock at 20 MHz
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ==========================================================
    // Access tasks; inputs change only at falling edges
    // ==========================================================
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_in);
        reg_wr = 1'b0;
        @(negedge clk_in);
    endtask

    // Read data holds until the next read, so sampling one cycle late is safe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_in);
        reg_rd = 1'b0;
        @(negedge clk_in);
        d = rdata;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the tests take some 2300 cycles, so 20000 means a hang
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        print_verdict();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial
    begin
        n_fail = 0;
        checks = 0;
        {reg_wr, reg_rd, low_power, overtemp, uv, wake_clear} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        txd = 1'b1;
        reset_n_in = 1'b0;
        cyc(4);
        reset_n_in = 1'b1;
        `CHK(slew, 2'b00)
        `CHK({active, drive, irq, wake}, 4'h0)
        reg_read(PHY_CTRL_OFFSET, v);
        `CHK(v & 8'hDF, PHY_CTRL_RESET)
        `CHK(v[BIT_RX_STATUS], 1'b1)
        // Unmapped place: write ignored, read gives zero
        reg_write(8'h19, 8'hFF);
        reg_read(8'h19, v);
        `CHK(v, 8'h00)
        reg_read(PHY_CTRL_OFFSET, v);
        `CHK(v & 8'hDF, PHY_CTRL_RESET)
        $display("test reset done");

        // Every slew code; code 11 falls back to the normal slope
        for (int i = 0; i < 4; i++)
        begin
            reg_write(PHY_CTRL_OFFSET, 8'h04 | 8'(i));
            `CHK(slew, (i == 3) ? 2'b00 : 2'(i))
            reg_read(PHY_CTRL_OFFSET, v);
            `CHK(v[1:0], 2'(i))
        end
        `CHK(active, 1'b1)
        $display("test slew done");

        txd = 1'b0;
        cyc(2);
        `CHK(drive, 1'b1)
        cyc(4);
        reg_read(PHY_CTRL_OFFSET, v);
        `CHK(v[BIT_RX_STATUS], 1'b0)
        `CHK(rxd, 1'b0)
        txd = 1'b1;
        cyc(2);
        `CHK(drive, 1'b0)
        reg_write(PHY_CTRL_OFFSET, 8'h14);
        `CHK(drive, 1'b1)
        reg_write(PHY_CTRL_OFFSET, 8'h10);
        `CHK({active, drive}, 2'b00)
        reg_write(PHY_CTRL_OFFSET, 8'h04);
        // Far node pulls the bus while we stay recessive
        fork
            u_node.send_dominant(20);
            begin
                cyc(8);
                reg_read(PHY_CTRL_OFFSET, v);
                `CHK(v[BIT_RX_STATUS], 1'b0)
            end
        join
        cyc(5);
        `CHK(rxd, 1'b1)
        $display("test transmit done");

        // Masked event: no request, then acknowledge the pending flag
        overtemp = 1'b1;
        cyc(6);
        `CHK(irq, 1'b0)
        reg_read(PHY_CTRL_OFFSET, v);
        overtemp = 1'b0;
        cyc(5);
        reg_write(PHY_CTRL_OFFSET, 8'h84);
        txd = 1'b0;
        cyc(2);
        `CHK(drive, 1'b1)
        overtemp = 1'b1;
        cyc(6);
        `CHK({drive, irq}, 2'b01)
        reg_read(PHY_CTRL_OFFSET, v);
        `CHK(v[BIT_OT_PRESENT], 1'b1)
        cyc(2);
        `CHK(irq, 1'b0)
        cyc(20);
        `CHK(irq, 1'b0)
        reg_read(PHY_CTRL_OFFSET, v);
        `CHK(v[BIT_OT_PRESENT], 1'b1)
        overtemp = 1'b0;
        cyc(6);
        `CHK(drive, 1'b0)
        txd = 1'b1;
        cyc(2);
        txd = 1'b0;
        cyc(2);
        `CHK(drive, 1'b1)
        overtemp = 1'b1;
        cyc(6);
        `CHK(irq, 1'b1)
        reg_read(PHY_CTRL_OFFSET, v);
        overtemp = 1'b0;
        txd = 1'b1;
        cyc(6);
        $display("test overtemp done");

        reg_write(PHY_CTRL_OFFSET, 8'h04);
        low_power = 1'b1;
        txd = 1'b0;
        cyc(2);
        `CHK(drive, 1'b0)
        u_node.send_dominant(100);
        cyc(6);
        `CHK(wake, 1'b0)
        u_node.send_dominant(WAKE_FILTER_CYCLES + 20);
        cyc(6);
        `CHK(wake, 1'b1)
        wake_clear = 1'b1;
        cyc(1);
        wake_clear = 1'b0;
        cyc(2);
        `CHK(wake, 1'b0)
        low_power = 1'b0;
        cyc(2);
        `CHK(drive, 1'b1)
        $display("test low power done");

        // Undervoltage while dominant: keep driving until the next release
        uv = 1'b1;
        cyc(5);
        `CHK(drive, 1'b1)
        txd = 1'b1;
        cyc(2);
        txd = 1'b0;
        cyc(3);
        `CHK(drive, 1'b0)
        uv = 1'b0;
        cyc(5);
        `CHK(drive, 1'b0)
        txd = 1'b1;
        cyc(1);
        txd = 1'b0;
        cyc(2);
        `CHK(drive, 1'b1)
        txd = 1'b1;
        uv = 1'b1;
        cyc(5);
        uv = 1'b0;
        cyc(5);
        txd = 1'b0;
        cyc(2);
        `CHK(drive, 1'b1)
        reg_write(PHY_CTRL_OFFSET, 8'h0C);
        uv = 1'b1;
        cyc(5);
        `CHK(drive, 1'b1)
        uv = 1'b0;
        txd = 1'b1;
        $display("test undervoltage done");
        cyc(2);
        // Reset in mid-run must clear a dirty control register
        reg_write(PHY_CTRL_OFFSET, 8'h9D);
        `CHK({slew, drive}, 3'b011)
        reset_n_in = 1'b0;
        cyc(4);
        reset_n_in = 1'b1;
        `CHK({slew, active, drive}, 4'h0)
        reg_read(PHY_CTRL_OFFSET, v);
        `CHK(v & 8'hDF, PHY_CTRL_RESET)
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule // lpc_top_bench

`default_nettype wire
